// file: src/cpwm_pkg.sv
// Shared constants and types for the complementary PWM and phase counting block.
// Assumes a 32-bit APB slave with byte addresses in the low eight bits.
package cpwm_pkg;
    localparam int CNT_W = 16;
    localparam int PHASES = 3;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PERIOD    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LEAD      = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LAG       = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_EDGE0     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_BUF0      = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_PWM_STAT  = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_QCTRL     = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_QIO       = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_QIRQ      = 8'h34;
    localparam logic [ADDR_W-1:0] OFS_QSTAT     = 8'h38;
    localparam logic [ADDR_W-1:0] OFS_QCNT      = 8'h3c;
    localparam logic [ADDR_W-1:0] OFS_QREGA     = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_QREGB     = 8'h44;
    localparam logic [ADDR_W-1:0] OFS_STEP      = 8'h04;

    // Field positions
    localparam int CTRL_CPWM = 0;
    localparam int CTRL_RUN  = 1;
    localparam int CTRL_BUF  = 2;
    localparam int CTRL_QRUN = 3;
    localparam int QC_PHASE  = 7;
    localparam int QC_CLR_LO = 5;
    localparam int ST_MATCH  = 0;
    localparam int ST_WRAP   = 1;
    localparam int QS_A      = 0;
    localparam int QS_B      = 1;
    localparam int QS_WRAP   = 2;

    // Values
    localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX    = 16'hffff;
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'hffff;
    localparam logic [CNT_W-1:0] EDGE_RST   = 16'hffff;
    localparam logic [1:0]       CLR_NONE   = 2'h0;
    localparam logic [1:0]       CLR_A      = 2'h1;
    localparam logic [1:0]       CLR_B      = 2'h2;

    typedef struct packed {
        logic quad_run;
        logic buf_en;
        logic run;
        logic cpwm_en;
    } pwm_ctrl_s;

    typedef enum logic [1:0] {
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } count_dir_e;
endpackage : cpwm_pkg

// file: src/cpwm_core.sv
// Complementary three-phase PWM pair generator and quadrature phase counter.
// Assumes an APB master on i_core_clk; quadrature and capture pins are asynchronous.
// Summary of operation
// - Two timer channels combine into three complementary non-overlapping PWM pairs.
// - Complementary mode turns six pins into PWM outputs; both counters go up/down.
// - Each phase output and its inverted partner form one non-overlapping pair.
// - Period limit holds the lead counter upper limit minus one.
// - Each edge register sets its pair's switching point by compare match.
// - Counters turn down on lead period match, turn up on lag underflow.
// - Matches per cycle come lead, lag, lag, lead, giving the gap.
// - An edge value above the period limit gives constant 0% or 100%.
// - Channel match flag sets only on period matches while counting up.
// - Wrap flag sets only on lag counter underflow, never overflow.
// - Buffered edges transfer only at up period match and lag underflow.
// - Phase counting exists on one channel; direction from quadrature relation.
// - Phase mode ignores prescale and edge select; clear, capture, flags stay.
// - Every edge of both quadrature inputs counts, four per input cycle.
`timescale 1ns/1ps
module cpwm_core
    import cpwm_pkg::*;
(
    // Clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_sys_rst,
    // APB slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // PWM pairs
    output logic      [PHASES-1:0] o_phase_out,
    output logic      [PHASES-1:0] o_phase_out_n,
    // DMA trigger on up-count period match
    output logic                   o_dma_req,
    // Quadrature and capture pins
    input  wire logic              i_quad_in_a,
    input  wire logic              i_quad_in_b,
    input  wire logic              i_cap_a,
    input  wire logic              i_cap_b,
    output logic                   o_quad_irq
);
    pwm_ctrl_s        ctrl_reg;
    count_dir_e       dir_reg;
    logic [CNT_W-1:0] period_limit_reg;
    logic [CNT_W-1:0] lead_counter;
    logic [CNT_W-1:0] lag_counter;
    logic [CNT_W-1:0] edge_reg [PHASES];
    logic [CNT_W-1:0] buf_reg  [PHASES];
    logic             match_a_flag;
    logic             wrap_flag;
    logic [7:0]       quad_control_reg;
    logic [1:0]       quad_io_control_reg;
    logic [2:0]       quad_irq_enable_reg;
    logic [2:0]       quad_status_reg;
    logic [CNT_W-1:0] quad_counter;
    logic [CNT_W-1:0] quad_reg_a;
    logic [CNT_W-1:0] quad_reg_b;
    logic [3:0]       sync1_reg;
    logic [3:0]       sync2_reg;
    logic [3:0]       last_reg;
    logic [31:0]      rdata_next;
    logic             mapped;
    logic             wr;
    logic             counting;
    logic             top_turn;
    logic             bot_turn;
    logic             xfer;
    logic             a_chg;
    logic             b_chg;
    logic             q_step;
    logic             q_up;
    logic             q_phase;
    logic             cap_a_evt;
    logic             cap_b_evt;
    logic             q_match_a;
    logic             q_match_b;
    logic             q_wrap;
    logic             q_clear;

    // Zero wait states; read data is taken in the setup cycle
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;
    assign wr        = i_psel && i_penable && i_pwrite && mapped;

    always_comb begin
        rdata_next = 32'h0000_0000;
        mapped     = 1'b1;
        case (i_paddr)
            OFS_CTRL:     rdata_next = {28'h000_0000, ctrl_reg};
            OFS_PERIOD:   rdata_next = {16'h0000, period_limit_reg};
            OFS_LEAD:     rdata_next = {16'h0000, lead_counter};
            OFS_LAG:      rdata_next = {16'h0000, lag_counter};
            OFS_PWM_STAT: rdata_next = {30'h0000_0000, wrap_flag, match_a_flag};
            OFS_QCTRL:    rdata_next = {24'h00_0000, quad_control_reg};
            OFS_QIO:      rdata_next = {30'h0000_0000, quad_io_control_reg};
            OFS_QIRQ:     rdata_next = {29'h0000_0000, quad_irq_enable_reg};
            OFS_QSTAT:    rdata_next = {29'h0000_0000, quad_status_reg};
            OFS_QCNT:     rdata_next = {16'h0000, quad_counter};
            OFS_QREGA:    rdata_next = {16'h0000, quad_reg_a};
            OFS_QREGB:    rdata_next = {16'h0000, quad_reg_b};
            default: begin
                mapped = 1'b0;
                for (int k = 0; k < PHASES; k++) begin
                    if (i_paddr == OFS_EDGE0 + ADDR_W'(k) * OFS_STEP) begin
                        rdata_next = {16'h0000, edge_reg[k]};
                        mapped     = 1'b1;
                    end
                    if (i_paddr == OFS_BUF0 + ADDR_W'(k) * OFS_STEP) begin
                        rdata_next = {16'h0000, buf_reg[k]};
                        mapped     = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable) begin
            o_prdata <= rdata_next;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_reg            <= '0;
            period_limit_reg    <= PERIOD_RST;
            quad_control_reg    <= 8'h00;
            quad_io_control_reg <= 2'h0;
            quad_irq_enable_reg <= 3'h0;
        end else if (wr) begin
            case (i_paddr)
                OFS_CTRL:   ctrl_reg            <= pwm_ctrl_s'(i_pwdata[3:0]);
                OFS_PERIOD: period_limit_reg    <= i_pwdata[CNT_W-1:0];
                OFS_QCTRL:  quad_control_reg    <= i_pwdata[7:0];
                OFS_QIO:    quad_io_control_reg <= i_pwdata[1:0];
                OFS_QIRQ:   quad_irq_enable_reg <= i_pwdata[2:0];
                default: ;
            endcase
        end
    end

    // Complementary counting: both counters share one direction
    assign counting = ctrl_reg.cpwm_en && ctrl_reg.run;
    assign top_turn = counting && dir_reg == DIR_UP && lead_counter == period_limit_reg;
    assign bot_turn = counting && dir_reg == DIR_DOWN && lag_counter == CNT_ZERO;
    assign xfer     = ctrl_reg.buf_en && (top_turn || bot_turn);
    assign o_dma_req = top_turn;

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dir_reg <= DIR_UP;
        end else if (!counting) begin
            dir_reg <= DIR_UP;
        end else if (top_turn) begin
            dir_reg <= DIR_DOWN;
        end else if (bot_turn) begin
            dir_reg <= DIR_UP;
        end
    end

    // Software may preset counters while stopped; a preset wins over a count
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lead_counter <= CNT_ZERO;
            lag_counter  <= CNT_ZERO;
        end else begin
            if (wr && i_paddr == OFS_LEAD) begin
                lead_counter <= i_pwdata[CNT_W-1:0];
            end else if (counting) begin
                lead_counter <= (dir_reg == DIR_UP) ? lead_counter + CNT_ONE
                                                    : lead_counter - CNT_ONE;
            end
            if (wr && i_paddr == OFS_LAG) begin
                lag_counter <= i_pwdata[CNT_W-1:0];
            end else if (counting) begin
                lag_counter <= (dir_reg == DIR_UP) ? lag_counter + CNT_ONE
                                                   : lag_counter - CNT_ONE;
            end
        end
    end

    // Flags: write 0 clears, a same-cycle event wins
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            match_a_flag <= 1'b0;
            wrap_flag    <= 1'b0;
        end else begin
            if (top_turn) begin
                match_a_flag <= 1'b1;
            end else if (wr && i_paddr == OFS_PWM_STAT && !i_pwdata[ST_MATCH]) begin
                match_a_flag <= 1'b0;
            end
            if (bot_turn) begin
                wrap_flag <= 1'b1;
            end else if (wr && i_paddr == OFS_PWM_STAT && !i_pwdata[ST_WRAP]) begin
                wrap_flag <= 1'b0;
            end
        end
    end

    generate
        for (genvar p = 0; p < PHASES; p++) begin : g_phase
            logic in_range;
            logic lead_hit;
            logic lag_hit;
            assign in_range = edge_reg[p] <= period_limit_reg;
            assign lead_hit = counting && in_range && lead_counter == edge_reg[p];
            assign lag_hit  = counting && in_range && lag_counter == edge_reg[p];

            always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    edge_reg[p] <= EDGE_RST;
                    buf_reg[p]  <= EDGE_RST;
                end else begin
                    if (wr && i_paddr == OFS_BUF0 + ADDR_W'(p) * OFS_STEP) begin
                        buf_reg[p] <= i_pwdata[CNT_W-1:0];
                    end
                    if (xfer) begin
                        edge_reg[p] <= buf_reg[p];
                    end else if (wr && i_paddr == OFS_EDGE0 + ADDR_W'(p) * OFS_STEP) begin
                        edge_reg[p] <= i_pwdata[CNT_W-1:0];
                    end
                end
            end

            // Lead hits drive the inverted side, lag hits the true side
            always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    o_phase_out[p]   <= 1'b0;
                    o_phase_out_n[p] <= 1'b0;
                end else if (!ctrl_reg.cpwm_en) begin
                    o_phase_out[p]   <= 1'b0;
                    o_phase_out_n[p] <= 1'b0;
                end else if (!ctrl_reg.run) begin
                    o_phase_out[p]   <= 1'b0;
                    o_phase_out_n[p] <= 1'b1;
                end else begin
                    if (lead_hit) begin
                        o_phase_out_n[p] <= (dir_reg == DIR_DOWN);
                    end
                    if (lag_hit) begin
                        o_phase_out[p] <= (dir_reg == DIR_UP);
                    end
                end
            end

            a_pair_exclusive: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
                !(o_phase_out[p] && o_phase_out_n[p]))
                else $error("phase pair driven high together");
            a_edge_out_range: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
                (counting && $past(counting) && !in_range && !$past(in_range))
                |-> $stable(o_phase_out[p]))
                else $error("out of range edge toggled output");
            a_edge_xfer_time: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
                ($changed(edge_reg[p]) && !$past(wr && i_paddr == OFS_EDGE0 + ADDR_W'(p) * OFS_STEP))
                |-> $past(ctrl_reg.buf_en && (top_turn || bot_turn)))
                else $error("edge changed outside a transfer moment");
        end
    endgenerate

    // Quadrature: two-flop sync, then a third stage for edge detection
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            last_reg  <= 4'h0;
        end else begin
            sync1_reg <= {i_cap_b, i_cap_a, i_quad_in_b, i_quad_in_a};
            sync2_reg <= sync1_reg;
            last_reg  <= sync2_reg;
        end
    end

    // Prescale and edge-select fields are not consulted in phase mode
    assign q_phase   = quad_control_reg[QC_PHASE] && ctrl_reg.quad_run;
    assign a_chg     = sync2_reg[0] ^ last_reg[0];
    assign b_chg     = sync2_reg[1] ^ last_reg[1];
    assign q_step    = q_phase && (a_chg ^ b_chg);
    assign q_up      = b_chg ? (sync2_reg[0] ^ sync2_reg[1])
                             : !(sync2_reg[0] ^ sync2_reg[1]);
    assign cap_a_evt = quad_io_control_reg[0] && sync2_reg[2] && !last_reg[2];
    assign cap_b_evt = quad_io_control_reg[1] && sync2_reg[3] && !last_reg[3];
    assign q_match_a = q_step && !quad_io_control_reg[0] && quad_counter == quad_reg_a;
    assign q_match_b = q_step && !quad_io_control_reg[1] && quad_counter == quad_reg_b;
    assign q_wrap    = q_step && (q_up ? quad_counter == CNT_MAX : quad_counter == CNT_ZERO);
    assign q_clear   = (quad_control_reg[QC_CLR_LO+:2] == CLR_A && (q_match_a || cap_a_evt))
                    || (quad_control_reg[QC_CLR_LO+:2] == CLR_B && (q_match_b || cap_b_evt));
    assign o_quad_irq = |(quad_status_reg & quad_irq_enable_reg);

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            quad_counter <= CNT_ZERO;
        end else if (q_clear) begin
            quad_counter <= CNT_ZERO;
        end else if (wr && i_paddr == OFS_QCNT) begin
            quad_counter <= i_pwdata[CNT_W-1:0];
        end else if (q_step) begin
            quad_counter <= q_up ? quad_counter + CNT_ONE : quad_counter - CNT_ONE;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            quad_reg_a <= CNT_MAX;
            quad_reg_b <= CNT_MAX;
        end else begin
            if (cap_a_evt) begin
                quad_reg_a <= quad_counter;
            end else if (wr && i_paddr == OFS_QREGA) begin
                quad_reg_a <= i_pwdata[CNT_W-1:0];
            end
            if (cap_b_evt) begin
                quad_reg_b <= quad_counter;
            end else if (wr && i_paddr == OFS_QREGB) begin
                quad_reg_b <= i_pwdata[CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            quad_status_reg <= 3'h0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                if ((k == QS_A && (q_match_a || cap_a_evt))
                    || (k == QS_B && (q_match_b || cap_b_evt))
                    || (k == QS_WRAP && q_wrap)) begin
                    quad_status_reg[k] <= 1'b1;
                end else if (wr && i_paddr == OFS_QSTAT && !i_pwdata[k]) begin
                    quad_status_reg[k] <= 1'b0;
                end
            end
        end
    end

    a_turn_down: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (counting && dir_reg == DIR_UP && lead_counter == period_limit_reg
         && !(wr && (i_paddr == OFS_LEAD || i_paddr == OFS_CTRL)))
        |=> dir_reg == DIR_DOWN && lead_counter == $past(period_limit_reg) + CNT_ONE)
        else $error("no down turn at period match");
    a_turn_up: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (bot_turn && !(wr && (i_paddr == OFS_LAG || i_paddr == OFS_CTRL)))
        |=> dir_reg == DIR_UP && lag_counter == CNT_MAX ##1 lag_counter == CNT_ZERO)
        else $error("no up turn at lag underflow");
    a_match_up_only: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $rose(match_a_flag) |-> $past(dir_reg == DIR_UP && lead_counter == period_limit_reg))
        else $error("match flag set outside up count");
    a_wrap_underflow: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $rose(wrap_flag) |-> $past(dir_reg == DIR_DOWN && lag_counter == CNT_ZERO))
        else $error("wrap flag set without underflow");
    a_quad_step_up: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (q_step && q_up && !q_clear && !wr)
        |=> quad_counter == $past(quad_counter) + CNT_ONE)
        else $error("quadrature up step missed");
    a_quad_step_down: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (q_step && !q_up && !q_clear && !wr)
        |=> quad_counter == $past(quad_counter) - CNT_ONE)
        else $error("quadrature down step missed");
endmodule : cpwm_core

// file: bench/pwm_partner.sv
// Far-side model: gate drivers watching the PWM pairs, and a quadrature encoder.
// Assumes one clock; the bench calls step between register accesses.
`timescale 1ns/1ps
module pwm_partner (
    // Clock
    input  wire logic       i_clk,
    // Gate drive pairs
    input  wire logic [2:0] i_hi,
    input  wire logic [2:0] i_lo,
    // Encoder pins and fault flag
    output logic            o_enc_a,
    output logic            o_enc_b,
    output logic            o_shoot
);
    logic [1:0] pos_reg = 2'd0;

    // Gray order 00, 01, 11, 10 as {a, b} counts up
    assign {o_enc_a, o_enc_b} = pos_reg ^ {1'b0, pos_reg[1]};

    initial o_shoot = 1'b0;
    // Sticky: both switches of a leg on at once would short the supply
    always @(posedge i_clk) begin
        if ((i_hi & i_lo) != 3'b000) o_shoot <= 1'b1;
    end

    task automatic step(input logic up, input int n);
        repeat (n) begin
            @(posedge i_clk) pos_reg <= up ? pos_reg + 2'd1 : pos_reg - 2'd1;
            // Five clocks per level, above pulse width and phase gap minimums
            repeat (4) @(posedge i_clk);
        end
    endtask : step
endmodule : pwm_partner

// file: bench/test_complementary_pwm_phase_counter.sv
// Self-checking bench for the PWM pair generator and phase counter.
// Assumes cpwm_core and pwm_partner compiled before it.
`timescale 1ns/1ps
module test_complementary_pwm_phase_counter
    import cpwm_pkg::*;
;
    localparam logic [15:0] EDGES [3] = '{16'h0003, 16'hffff, 16'h0002};
    logic              i_core_clk = 1'b0;
    logic              i_sys_rst  = 1'b1;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr  = '0;
    logic [31:0]       pwdata = '0, prdata, rnd = 32'hbcd3_73fe;
    logic              pready, pslverr, dma, irq, enc_a, enc_b, shoot;
    logic              cap_a = 1'b0;
    logic [2:0]        ph, ph_n, ph_prev = '0;
    logic [32:0]       exp_q[$];
    int                fails = 0, tests_run = 0, cycles = 0, n, chg0 = 0, chg1 = 0;

    always #12.5 i_core_clk = ~i_core_clk;

    cpwm_core i_cpwm_core (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_phase_out(ph), .o_phase_out_n(ph_n), .o_dma_req(dma),
        .i_quad_in_a(enc_a), .i_quad_in_b(enc_b), .i_cap_a(cap_a), .i_cap_b(1'b0),
        .o_quad_irq(irq));

    pwm_partner i_pwm_partner (.i_clk(i_core_clk), .i_hi(ph), .i_lo(ph_n),
        .o_enc_a(enc_a), .o_enc_b(enc_b), .o_shoot(shoot));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] expd);
        tests_run++;
        if (seen !== expd) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, expd, seen);
        end
    endtask : check

    task automatic end_of_test;
        if (fails == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    // Reads note {pslverr, prdata} expected; the monitor below compares
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e = '0);
        @(posedge i_core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        if (!wr) exp_q.push_back(e);
        @(posedge i_core_clk);
        penable <= 1'b1;
        do @(posedge i_core_clk); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // Count edges up to the next cycle with the turn pulse high
    task automatic wait_dma(output int c);
        c = 0;
        do begin @(posedge i_core_clk); #1; c++; end while (dma !== 1'b1 && c < 100);
    endtask : wait_dma

    always @(posedge i_core_clk) begin
        if (psel && penable && pready && !pwrite)
            check("read", {pslverr, prdata}, exp_q.pop_front());
    end

    always @(posedge i_core_clk) begin
        cycles++;
        chg0 += int'(ph[0] != ph_prev[0]);
        chg1 += int'(ph[1] != ph_prev[1]);
        ph_prev <= ph;
        if (cycles == 6000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        repeat (3) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        apb(0, OFS_PERIOD, 0, {17'h0, PERIOD_RST});
        apb(0, 8'h80, 0, {1'b1, 32'h0});
        apb(1, OFS_PERIOD, 32'h4);
        apb(1, OFS_LEAD, 32'h2);
        apb(1, OFS_LAG, 32'h0);
        // Edges at or above T; one beyond the period, never restored
        for (int i = 0; i < 3; i++) begin
            apb(1, OFS_EDGE0 + 8'(4 * i), {16'h0, EDGES[i]});
            apb(1, OFS_BUF0 + 8'(4 * i), {16'h0, EDGES[i]});
        end
        // Mode first, so every inverted side starts high before counting
        apb(1, OFS_CTRL, 32'h5);
        apb(1, OFS_CTRL, 32'h7);
        wait_dma(n);
        chg0 = 0;
        chg1 = 0;
        wait_dma(n);
        check("turn period", 33'(n), 33'd8);
        // Written after the top turn, so it moves at the bottom one
        // Later top transfers keep 2, outside the top band
        apb(1, OFS_BUF0, 32'h2);
        repeat (20) @(posedge i_core_clk);
        apb(0, OFS_EDGE0, 0, 33'h2);
        apb(0, OFS_PWM_STAT, 0, 33'h3);
        check("phase0 toggles", 33'(chg0 != 0), 33'd1);
        check("phase1 fixed", 33'(chg1), 33'd0);
        check("phase1 complement", 33'(ph_n[1]), 33'd1);
        check("no overlap", 33'(shoot), 33'd0);
        apb(1, OFS_CTRL, 32'h1);
        repeat (3) @(posedge i_core_clk);
        check("stopped", 33'({ph_n, ph}), 33'h38);
        rnd = lfsr(rnd);
        apb(1, OFS_QCTRL, {24'h0, 3'b100, rnd[4:0]});
        apb(1, OFS_QIRQ, 32'h4);
        apb(1, OFS_CTRL, 32'h8);
        i_pwm_partner.step(1'b1, 6);
        repeat (4) @(posedge i_core_clk);
        apb(0, OFS_QCNT, 0, 33'h6);
        i_pwm_partner.step(1'b0, 10);
        repeat (4) @(posedge i_core_clk);
        apb(0, OFS_QCNT, 0, 33'hfffc);
        apb(0, OFS_QSTAT, 0, 33'h7);
        check("quad irq", 33'(irq), 33'd1);
        // Capture A with A as clear source: value saved, counter zeroed
        apb(1, OFS_QIO, 32'h1);
        apb(1, OFS_QCTRL, {24'h0, 3'b101, rnd[9:5]});
        @(posedge i_core_clk) cap_a <= 1'b1;
        repeat (5) @(posedge i_core_clk);
        apb(0, OFS_QREGA, 0, 33'hfffc);
        apb(0, OFS_QCNT, 0, 33'h0);
        end_of_test();
    end
endmodule : test_complementary_pwm_phase_counter
